// file: rtl/flash_status_pkg.sv
/*
 * constants for the status and configuration register logic of the serial flash:
 * opcodes, bit positions, guard encodings, timing and frame states.
 * assumes a 40 MHz system clock and mode 0 serial framing.
 */
package flash_status_pkg;
   // opcodes
   localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
   localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
   localparam logic [7:0] OP_VOL_ENABLE  = 8'h50;
   localparam logic [7:0] OP_STAT_WR_LO  = 8'h01;
   localparam logic [7:0] OP_STAT_WR_HI  = 8'h31;
   localparam logic [7:0] OP_STAT_RD_LO  = 8'h05;
   localparam logic [7:0] OP_STAT_RD_HI  = 8'h35;
   localparam logic [7:0] OP_SUSPEND     = 8'h75;
   localparam logic [7:0] OP_RESUME      = 8'h7A;

   // status byte low positions
   localparam int BUSY_POS       = 0;
   localparam int LATCH_POS      = 1;
   localparam int AREA_LSB       = 2;
   localparam int GUARD_LOW_POS  = 7;
   // status byte high positions
   localparam int GUARD_HIGH_POS = 0;
   localparam int QUAD_POS       = 1;
   localparam int PSUS_POS       = 2;
   localparam int LOCK_LSB       = 3;
   localparam int INVERT_POS     = 6;
   localparam int ESUS_POS       = 7;

   // writable positions of each byte
   localparam logic [7:0] LOW_WR_MASK  = 8'hFC;
   localparam logic [7:0] HIGH_WR_MASK = 8'h7B;
   localparam logic [15:0] CFG_RESET   = 16'h0000;

   // register guard encodings {high, low}
   localparam logic [1:0] GUARD_SOFT     = 2'h0;
   localparam logic [1:0] GUARD_HW       = 2'h1;
   localparam logic [1:0] GUARD_LOCKDOWN = 2'h2;

   localparam logic [4:0] OPCODE_BITS = 5'h08;
   localparam logic [4:0] WRITE_BITS  = 5'h10;

   localparam int CLK_PERIOD_NS   = 25;
   localparam int STAT_WR_TIME_NS = 5000;
   localparam int STAT_WR_CYCLES  = (STAT_WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_CNT_W        = $clog2(STAT_WR_CYCLES + 1);

   typedef enum logic [1:0] {
      FR_IDLE   = 2'b00,
      FR_OPCODE = 2'b01,
      FR_READ   = 2'b10,
      FR_DATA   = 2'b11
   } frame_state_t;
endpackage : flash_status_pkg

// file: rtl/flash_status_write_control.sv
/*
 * status and configuration register logic of a serial flash: write latch,
 * busy flag, page locks, suspend flags, quad pin enable, status write and
 * volatile status write, register guard protection, status byte readout.
 * assumes external array sequencers report busy, done, abort and an opcode
 * seen pulse, and the non-volatile store presents its bits at nv_status.
 */
// Overview of operation
// - no array or non-volatile status write without latch
// - write latch clear after reset
// - latch cleared on disable, completion or abort
// - partial opcode abort keeps latch
// - busy high through each self-timed cycle
// - lock bits mark pages locked, block writes
// - erase suspended flag set/cleared by commands
// - program suspended flag set/cleared by commands
// - quad enable turns pins bidirectional
// - status write only after exactly eight data bits
// - chip select rise starts cycle, latch clears after
// - only writable bits change, refused when protected
// - low byte layout guard, area, latch, busy
// - high byte layout erase suspend, invert, locks, program suspend, quad, guard
// - working copy loaded from non-volatile at reset
// - volatile enable grants one low status write
// - guard 01 with pin low locks register outside quad mode
// - guard 10 locks until power cycle
// - status byte repeats while clocked
`timescale 1ns/1ps
module flash_status_write_control (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        cs_n,
   input  wire logic        sck,
   input  wire logic        si,
   output logic             so,
   output logic             so_oe,
   input  wire logic        wp_n_in,
   output logic             wp_n_out,
   output logic             wp_n_oe,
   input  wire logic        hold_n_in,
   output logic             hold_n_out,
   output logic             hold_n_oe,
   input  wire logic        quad_drive,
   input  wire logic [1:0]  quad_dout,
   output logic             hold_active,
   input  wire logic [15:0] nv_status,
   output logic             nv_write,
   output logic [15:0]      nv_data,
   input  wire logic        array_cmd_seen,
   input  wire logic        sec_cmd,
   input  wire logic [1:0]  sec_page,
   input  wire logic        array_busy,
   input  wire logic        array_done,
   input  wire logic        array_abort,
   input  wire logic        erase_active,
   input  wire logic        program_active,
   output logic             array_go,
   output logic             suspend_go,
   output logic             resume_go,
   output logic             write_latch_flag,
   output logic             busy_flag,
   output logic [2:0]       page_lock,
   output logic [4:0]       area_guard,
   output logic             guard_invert,
   output logic             quad_pins_enable
);
   localparam int WR_CYC = flash_status_pkg::STAT_WR_CYCLES;

   link_if lk ();
   serial_frontend u_fe (
      .clk    (clk),
      .resetn (resetn),
      .cs_n   (cs_n),
      .sck    (sck),
      .si     (si),
      .lk     (lk)
   );

   flash_status_pkg::frame_state_t state_ff;
   logic [1:0]                     pin1_ff;
   logic [1:0]                     pin2_ff;
   logic [15:0]                    cfg_ff;
   logic                           loaded_ff;
   logic                           write_latch_ff;
   logic                           vol_armed_ff;
   logic                           erase_susp_ff;
   logic                           prog_susp_ff;
   logic                           wr_busy_ff;
   logic [flash_status_pkg::WR_CNT_W-1:0] wr_cnt_ff;
   logic [15:0]                    pend_ff;
   logic [7:0]                     op_ff;
   logic                           rd_high_ff;
   logic [2:0]                     out_idx_ff;
   logic [7:0]                     out_sh_ff;
   logic                           so_ff;
   logic                           nv_write_ff;
   logic                           array_go_ff;
   logic                           suspend_go_ff;
   logic                           resume_go_ff;

   logic [7:0] stat_low;
   logic [7:0] stat_high;
   logic [1:0] guard;
   logic       wp_level;
   logic       locked;
   logic       end8;
   logic       sw_end;
   logic       vol_path;
   logic       sw_ok;
   logic       sw_abort;
   logic       sw_done;
   logic       we_set;
   logic       busy;

   // merges a written byte into the working copy, read-only positions kept
   function automatic logic [15:0] merge(input logic [15:0] cur, input logic high, input logic [7:0] d);
      logic [15:0] r;
      r = cur;
      if (high) begin
         r[15:8] = (d & flash_status_pkg::HIGH_WR_MASK) | (cur[15:8] & ~flash_status_pkg::HIGH_WR_MASK);
      end else begin
         r[7:0] = (d & flash_status_pkg::LOW_WR_MASK) | (cur[7:0] & ~flash_status_pkg::LOW_WR_MASK);
      end
      return r;
   endfunction : merge

   function automatic logic is_op(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction : is_op

   // wp at bit 1, hold at bit 0
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin1_ff <= 2'h3;
         pin2_ff <= 2'h3;
      end else begin
         pin1_ff <= {wp_n_in, hold_n_in};
         pin2_ff <= pin1_ff;
      end
   end

   // byte layouts
   assign stat_low  = {cfg_ff[7:2], write_latch_ff, busy};
   assign stat_high = {erase_susp_ff, cfg_ff[14:11], prog_susp_ff, cfg_ff[9:8]};
   assign guard     = {cfg_ff[8 + flash_status_pkg::GUARD_HIGH_POS], cfg_ff[flash_status_pkg::GUARD_LOW_POS]};
   // in quad mode the pin carries data, so its protection role is dropped
   assign wp_level  = cfg_ff[8 + flash_status_pkg::QUAD_POS] | pin2_ff[1];
   assign locked    = (guard == flash_status_pkg::GUARD_LOCKDOWN)
                    | ((guard == flash_status_pkg::GUARD_HW) & ~wp_level);
   assign busy      = wr_busy_ff | array_busy;

   assign end8     = lk.frame_end & (lk.bit_cnt == flash_status_pkg::OPCODE_BITS) & (state_ff != flash_status_pkg::FR_IDLE);
   assign we_set   = end8 & is_op(op_ff, flash_status_pkg::OP_WR_ENABLE) & ~busy;
   assign sw_end   = lk.frame_end & (state_ff == flash_status_pkg::FR_DATA);
   assign vol_path = vol_armed_ff & is_op(op_ff, flash_status_pkg::OP_STAT_WR_LO);
   assign sw_ok    = sw_end & (lk.bit_cnt == flash_status_pkg::WRITE_BITS)
                   & (write_latch_ff | vol_path) & ~locked & ~busy;
   assign sw_abort = sw_end & ~sw_ok;
   assign sw_done  = wr_busy_ff & (wr_cnt_ff == (flash_status_pkg::WR_CNT_W)'(WR_CYC - 1));

   // frame sequencing: opcode, then data, status readout or ignore
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff   <= flash_status_pkg::FR_IDLE;
         op_ff      <= 8'h00;
         rd_high_ff <= 1'b0;
      end else if (lk.frame_start) begin
         state_ff <= flash_status_pkg::FR_OPCODE;
      end else if (lk.frame_end) begin
         state_ff <= flash_status_pkg::FR_IDLE;
      end else if (lk.byte_done && lk.bit_cnt == flash_status_pkg::OPCODE_BITS) begin
         op_ff <= lk.shift;
         case (state_ff)
            flash_status_pkg::FR_OPCODE: begin
               if (is_op(lk.shift, flash_status_pkg::OP_STAT_RD_LO) || is_op(lk.shift, flash_status_pkg::OP_STAT_RD_HI)) begin
                  state_ff   <= flash_status_pkg::FR_READ;
                  rd_high_ff <= is_op(lk.shift, flash_status_pkg::OP_STAT_RD_HI);
               end else if (is_op(lk.shift, flash_status_pkg::OP_STAT_WR_LO) || is_op(lk.shift, flash_status_pkg::OP_STAT_WR_HI)) begin
                  state_ff <= flash_status_pkg::FR_DATA;
               end
            end
            default: begin
               state_ff <= state_ff;
            end
         endcase
      end
   end

   // working copy: loaded once after reset release, then updated by writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_ff    <= flash_status_pkg::CFG_RESET;
         loaded_ff <= 1'b0;
      end else if (!loaded_ff) begin
         loaded_ff <= 1'b1;
         cfg_ff    <= merge(merge(flash_status_pkg::CFG_RESET, 1'b0, nv_status[7:0]), 1'b1, nv_status[15:8]);
         if ({nv_status[8 + flash_status_pkg::GUARD_HIGH_POS], nv_status[flash_status_pkg::GUARD_LOW_POS]}
             == flash_status_pkg::GUARD_LOCKDOWN) begin
            cfg_ff[8 + flash_status_pkg::GUARD_HIGH_POS] <= 1'b0;
            cfg_ff[flash_status_pkg::GUARD_LOW_POS]      <= 1'b0;
         end
      end else if (sw_ok && vol_path) begin
         cfg_ff <= merge(cfg_ff, 1'b0, lk.shift);
      end else if (sw_done) begin
         cfg_ff <= pend_ff;
      end
   end

   // self-timed status write cycle; a refused write never starts it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_busy_ff <= 1'b0;
         wr_cnt_ff  <= '0;
         pend_ff    <= 16'h0000;
      end else if (sw_ok && !vol_path) begin
         wr_busy_ff <= 1'b1;
         wr_cnt_ff  <= '0;
         pend_ff    <= merge(cfg_ff, is_op(op_ff, flash_status_pkg::OP_STAT_WR_HI), lk.shift);
      end else if (sw_done) begin
         wr_busy_ff <= 1'b0;
      end else if (wr_busy_ff) begin
         wr_cnt_ff <= wr_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nv_write_ff <= 1'b0;
      end else begin
         nv_write_ff <= sw_done;
      end
   end

   // set wins over every clear; a partial opcode never reaches these terms
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_latch_ff <= 1'b0;
      end else if (we_set) begin
         write_latch_ff <= 1'b1;
      end else if ((end8 && is_op(op_ff, flash_status_pkg::OP_WR_DISABLE)) || sw_done
                   || (sw_abort && !vol_path) || array_done || array_abort) begin
         write_latch_ff <= 1'b0;
      end
   end

   // volatile grant lasts for exactly one following low status write frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vol_armed_ff <= 1'b0;
      end else if (end8 && is_op(op_ff, flash_status_pkg::OP_VOL_ENABLE)) begin
         vol_armed_ff <= 1'b1;
      end else if (sw_end && is_op(op_ff, flash_status_pkg::OP_STAT_WR_LO)) begin
         vol_armed_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         erase_susp_ff <= 1'b0;
         prog_susp_ff  <= 1'b0;
         suspend_go_ff <= 1'b0;
         resume_go_ff  <= 1'b0;
      end else begin
         suspend_go_ff <= end8 & is_op(op_ff, flash_status_pkg::OP_SUSPEND) & (erase_active | program_active);
         resume_go_ff  <= end8 & is_op(op_ff, flash_status_pkg::OP_RESUME);
         if (end8 && is_op(op_ff, flash_status_pkg::OP_SUSPEND)) begin
            erase_susp_ff <= erase_susp_ff | erase_active;
            prog_susp_ff  <= prog_susp_ff | program_active;
         end else if (end8 && is_op(op_ff, flash_status_pkg::OP_RESUME)) begin
            erase_susp_ff <= 1'b0;
            prog_susp_ff  <= 1'b0;
         end
      end
   end

   // array commands pass only with the latch set and the page unlocked
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         array_go_ff <= 1'b0;
      end else begin
         array_go_ff <= array_cmd_seen & write_latch_ff & ~busy
                      & ~(sec_cmd & (sec_page != 2'h3) & cfg_ff[8 + flash_status_pkg::LOCK_LSB + sec_page]);
      end
   end

   // readout: drive on falling sck, fresh byte at each byte start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_idx_ff <= 3'h0;
         out_sh_ff  <= 8'h00;
         so_ff      <= 1'b0;
      end else if (lk.frame_start) begin
         out_idx_ff <= 3'h0;
      end else if (lk.sck_fall && state_ff == flash_status_pkg::FR_READ) begin
         out_idx_ff <= out_idx_ff + 3'h1;
         if (out_idx_ff == 3'h0) begin
            so_ff     <= rd_high_ff ? stat_high[7] : stat_low[7];
            out_sh_ff <= {rd_high_ff ? stat_high[6:0] : stat_low[6:0], 1'b0};
         end else begin
            so_ff     <= out_sh_ff[7];
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
         end
      end
   end

   assign so               = so_ff;
   assign so_oe            = lk.cs_active & (state_ff == flash_status_pkg::FR_READ);
   assign wp_n_out         = quad_dout[0];
   assign hold_n_out       = quad_dout[1];
   assign wp_n_oe          = cfg_ff[8 + flash_status_pkg::QUAD_POS] & quad_drive;
   assign hold_n_oe        = cfg_ff[8 + flash_status_pkg::QUAD_POS] & quad_drive;
   assign hold_active      = ~cfg_ff[8 + flash_status_pkg::QUAD_POS] & ~pin2_ff[0];
   assign nv_write         = nv_write_ff;
   assign nv_data          = cfg_ff;
   assign array_go         = array_go_ff;
   assign suspend_go       = suspend_go_ff;
   assign resume_go        = resume_go_ff;
   assign write_latch_flag = write_latch_ff;
   assign busy_flag        = busy;
   assign page_lock        = cfg_ff[8 + flash_status_pkg::LOCK_LSB +: 3];
   assign area_guard       = cfg_ff[flash_status_pkg::AREA_LSB +: 5];
   assign guard_invert     = cfg_ff[8 + flash_status_pkg::INVERT_POS];
   assign quad_pins_enable = cfg_ff[8 + flash_status_pkg::QUAD_POS];

   sequence s_write_start;
      sw_ok & ~vol_path;
   endsequence

   sequence s_busy_run;
      wr_busy_ff [*8];
   endsequence

   a_go_needs_latch: assert property (@(posedge clk) disable iff (!resetn)
      array_go_ff |-> $past(write_latch_ff)) else $error("array command passed without latch");
   a_latch_reset: assert property (@(posedge clk) disable iff (!resetn)
      !loaded_ff |-> !write_latch_ff) else $error("latch set right after reset");
   a_latch_on_done: assert property (@(posedge clk) disable iff (!resetn)
      (array_done && !we_set) |=> !write_latch_ff) else $error("latch survived completion");
   a_latch_partial: assert property (@(posedge clk) disable iff (!resetn)
      (lk.frame_end && lk.bit_cnt < flash_status_pkg::OPCODE_BITS && write_latch_ff
       && !array_done && !array_abort && !sw_done) |=> write_latch_ff) else $error("partial opcode cleared latch");
   a_busy_cycle: assert property (@(posedge clk) disable iff (!resetn)
      s_write_start |=> s_busy_run ##0 busy_flag) else $error("busy dropped during status write");
   a_erase_susp: assert property (@(posedge clk) disable iff (!resetn)
      (end8 && op_ff == flash_status_pkg::OP_SUSPEND && erase_active) |=> erase_susp_ff) else $error("erase suspend flag not set");
   a_prog_susp: assert property (@(posedge clk) disable iff (!resetn)
      (end8 && op_ff == flash_status_pkg::OP_RESUME) |=> !prog_susp_ff) else $error("program suspend flag not cleared");
   a_quad_drive: assert property (@(posedge clk) disable iff (!resetn)
      wp_n_oe |-> quad_pins_enable) else $error("guard pin driven outside quad mode");
   a_write_frame: assert property (@(posedge clk) disable iff (!resetn)
      sw_ok |-> lk.bit_cnt == 5'h10) else $error("status write on misplaced edge");
   a_cycle_clears: assert property (@(posedge clk) disable iff (!resetn)
      s_write_start |-> ##[200:202] (!wr_busy_ff && !write_latch_ff)) else $error("cycle end wrong");
   a_protect: assert property (@(posedge clk) disable iff (!resetn)
      (sw_end && locked) |=> $stable(cfg_ff) && !wr_busy_ff) else $error("protected write executed");
endmodule : flash_status_write_control

// file: rtl/link_if.sv
/*
 * decoded serial link events passed from the pin front end to the status core.
 * all members are in the clk domain; pins are synchronised before reaching here.
 */
`timescale 1ns/1ps
interface link_if;
   logic       cs_active;
   logic       frame_start;
   logic       frame_end;
   logic       sck_rise;
   logic       sck_fall;
   logic       byte_done;
   logic [4:0] bit_cnt;
   logic [7:0] shift;
   modport fe   (output cs_active, frame_start, frame_end, sck_rise, sck_fall, byte_done, bit_cnt, shift);
   modport core (input  cs_active, frame_start, frame_end, sck_rise, sck_fall, byte_done, bit_cnt, shift);
endinterface : link_if

// file: rtl/serial_frontend.sv
/*
 * serial front end: synchronises chip select, serial clock and serial input,
 * finds clock edges and frame boundaries, counts bits and shifts data in.
 * assumes the serial clock is much slower than clk (at least 4 clk per half period).
 */
`timescale 1ns/1ps
module serial_frontend (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   link_if.fe        lk
);
   logic [2:0] s1_ff;
   logic [2:0] s2_ff;
   logic       cs_prev_ff;
   logic       sck_prev_ff;
   logic [4:0] cnt_ff;
   logic [7:0] shift_ff;
   logic       done_ff;

   // two-stage synchronisers, cs at bit 2, sck at bit 1, si at bit 0
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_ff <= 3'h7;
         s2_ff <= 3'h7;
      end else begin
         s1_ff <= {cs_n, sck, si};
         s2_ff <= s1_ff;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_prev_ff  <= 1'b1;
         sck_prev_ff <= 1'b1;
      end else begin
         cs_prev_ff  <= s2_ff[2];
         sck_prev_ff <= s2_ff[1];
      end
   end

   assign lk.cs_active   = ~s2_ff[2];
   assign lk.frame_start = ~s2_ff[2] & cs_prev_ff;
   assign lk.frame_end   = s2_ff[2] & ~cs_prev_ff;
   assign lk.sck_rise    = ~s2_ff[2] & s2_ff[1] & ~sck_prev_ff;
   assign lk.sck_fall    = ~s2_ff[2] & ~s2_ff[1] & sck_prev_ff;

   // count saturates so overlong frames stay distinguishable from exact ones
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff   <= 5'h00;
         shift_ff <= 8'h00;
         done_ff  <= 1'b0;
      end else begin
         done_ff <= lk.sck_rise & (cnt_ff[2:0] == 3'h7) & (cnt_ff != 5'h1F);
         if (lk.frame_start) begin
            cnt_ff <= 5'h00;
         end else if (lk.sck_rise) begin
            shift_ff <= {shift_ff[6:0], s2_ff[0]};
            if (cnt_ff != 5'h1F) begin
               cnt_ff <= cnt_ff + 5'h01;
            end
         end
      end
   end

   assign lk.bit_cnt   = cnt_ff;
   assign lk.shift     = shift_ff;
   assign lk.byte_done = done_ff;
endmodule : serial_frontend

// file: sim/host_model.sv
/* host controller model: mode 0 frames on chip select, serial clock and data in.
   assumes clk is the system clock; the link half period is 4 clk. */
`timescale 1ns/1ps
module host_model (
   input  wire logic clk,
   input  wire logic so,
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   logic [23:0] q;
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end
   // sends the top n bits of v msb first; fewer than a whole unit makes an aborted frame
   task automatic xfer(input logic [23:0] v, input int n);
      @(posedge clk);
      #1 cs_n = 1'b0;
      // data changes while sck is low, both halves 100 ns
      for (int i = 23; i > 23 - n; i--) begin
         si = v[i];
         #100 sck = 1'b1;
         q = {q[22:0], so};
         #100 sck = 1'b0;
      end
      #100 cs_n = 1'b1;
      // released line must not keep looking valid
      si = ~si;
      #400;
   endtask : xfer
   task automatic op(input logic [7:0] o);
      xfer({o, 16'h0000}, 8);
   endtask : op
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      xfer({o, d, 8'h00}, 16);
   endtask : wr
   task automatic rd(input logic [7:0] o, output logic [15:0] r);
      xfer({o, 16'h0000}, 24);
      r = q[15:0];
   endtask : rd
endmodule : host_model

// file: sim/testbench.sv
/* self-checking bench of the status register block behind its serial pins.
   assumes host_model drives the link; array sequencer lines are driven here. */
`timescale 1ns/1ps
module testbench;
   logic clk, resetn, cs_n, sck, si, so, so_oe, wp_n_in, wp_n_out, wp_n_oe, hold_n_in, hold_n_out;
   logic hold_n_oe, quad_drive, hold_active, nv_write, array_cmd_seen, sec_cmd, array_busy;
   logic array_done, array_abort, erase_active, program_active, array_go, suspend_go, resume_go;
   logic write_latch_flag, busy_flag, guard_invert, quad_pins_enable;
   logic [1:0]  quad_dout, sec_page;
   logic [2:0]  page_lock;
   logic [4:0]  area_guard;
   logic [15:0] nv_status, nv_data, r;
   int          fails, num_checks;
   int          n_nvw, n_sus, n_res, n_oe;
   flash_status_write_control DUT (.*);
   host_model host (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
   // pulses are counted on the falling edge, clear of the edge that launches them
   always @(negedge clk) begin
      n_nvw += nv_write;
      n_sus += suspend_go;
      n_res += resume_go;
      n_oe  += so_oe;
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic cmd(input logic s, input logic [1:0] p);
      @(posedge clk);
      #1 {array_cmd_seen, sec_cmd, sec_page} = {1'b1, s, p};
      @(posedge clk);
      #1 array_cmd_seen = 1'b0;
   endtask : cmd
   task automatic poll();
      for (int i = 0; i < 6 && r[0] !== 1'b0; i++) host.rd(8'h05, r);
   endtask : poll
   task automatic t_latch();
      host.op(8'h06);
      chk(write_latch_flag, 1'b1);
      host.xfer({8'h04, 16'h0000}, 4);
      chk(write_latch_flag, 1'b1);
      host.op(8'h04);
      chk(write_latch_flag, 1'b0);
   endtask : t_latch
   task automatic t_gate();
      cmd(1'b0, 2'h0);
      chk(array_go, 1'b0);
      host.op(8'h06);
      cmd(1'b1, 2'h2);
      chk(array_go, 1'b0);
      cmd(1'b0, 2'h0);
      chk(array_go, 1'b1);
      array_done = 1'b1;
      @(posedge clk);
      #1 array_done = 1'b0;
      @(posedge clk);
      #1 chk(write_latch_flag, 1'b0);
   endtask : t_gate
   task automatic t_swrite();
      host.op(8'h06);
      host.wr(8'h01, 8'hFF);
      host.rd(8'h05, r);
      chk(r[8], 1'b1);
      poll();
      chk(r[7:0], 8'hFC);
      chk(write_latch_flag, 1'b0);
      chk(area_guard, 5'h1F);
      chk(nv_data, 16'h38FC);
      chk(n_nvw[3:0], 4'h1);
   endtask : t_swrite
   task automatic t_protect();
      wp_n_in = 1'b0;
      host.op(8'h06);
      host.wr(8'h01, 8'h00);
      chk(area_guard, 5'h1F);
      chk(busy_flag, 1'b0);
      wp_n_in = 1'b1;
      host.wr(8'h01, 8'h00);
      chk(area_guard, 5'h1F);
      host.op(8'h06);
      host.xfer({8'h01, 16'h0000}, 15);
      chk(area_guard, 5'h1F);
      chk(write_latch_flag, 1'b0);
      host.op(8'h50);
      host.wr(8'h01, 8'h00);
      chk({busy_flag, area_guard}, 6'h00);
   endtask : t_protect
   task automatic t_high();
      host.op(8'h06);
      host.wr(8'h31, 8'h7A);
      r = 16'h0001;
      poll();
      chk({quad_pins_enable, guard_invert}, 2'h3);
      quad_drive = 1'b1;
      #25 chk({wp_n_oe, hold_n_oe}, 2'h3);
      quad_drive = 1'b0;
      host.rd(8'h35, r);
      chk(r, 16'h7A7A);
      chk({so_oe, n_oe != 0}, 2'h1);
   endtask : t_high
   task automatic t_susp();
      for (int i = 0; i < 2; i++) begin
         {erase_active, program_active} = (i == 0) ? 2'h2 : 2'h1;
         host.op(8'h75);
         host.rd(8'h35, r);
         chk(r[15:8], (i == 0) ? 8'hFA : 8'h7E);
         host.op(8'h7A);
         host.rd(8'h35, r);
         chk(r[15:8], 8'h7A);
      end
      chk({n_sus[3:0], n_res[3:0]}, 8'h22);
   endtask : t_susp
   task automatic t_lock();
      host.op(8'h06);
      host.wr(8'h31, 8'h01);
      r = 16'h0001;
      poll();
      host.op(8'h06);
      host.wr(8'h01, 8'h7C);
      chk({write_latch_flag, busy_flag, area_guard}, 7'h00);
      // the store still holds lock-down; a power cycle must bring the guard back as 00
      nv_status = 16'h0100;
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (2) @(posedge clk);
      host.rd(8'h35, r);
      chk(r[7:0], 8'h00);
   endtask : t_lock
   task automatic t_pins();
      {quad_drive, quad_dout, hold_n_in} = 4'hC;
      #100 chk({hold_n_out, wp_n_out, hold_active, wp_n_oe}, 4'hA);
      {quad_drive, hold_n_in} = 2'h1;
      array_busy = 1'b1;
      host.op(8'h06);
      chk({busy_flag, write_latch_flag}, 2'h2);
      array_busy = 1'b0;
      host.op(8'h06);
      array_abort = 1'b1;
      @(posedge clk);
      #1 array_abort = 1'b0;
      chk(write_latch_flag, 1'b0);
   endtask : t_pins
   initial begin
      {resetn, quad_drive, quad_dout, array_cmd_seen, sec_cmd, sec_page, array_busy} = '0;
      {array_done, array_abort, erase_active, program_active, fails, num_checks} = '0;
      {wp_n_in, hold_n_in} = 2'h3;
      // locks on all pages, area guard 3
      nv_status = 16'h380C;
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(write_latch_flag, 1'b0);
      chk({page_lock, area_guard}, 8'hE3);
      t_latch();
      t_gate();
      t_swrite();
      t_protect();
      t_high();
      t_susp();
      t_lock();
      t_pins();
      finish_test();
   end
   initial begin
      #1000000;
      fails++;
      finish_test();
   end
endmodule : testbench
